// [hdl/io_port_pkg.sv]
// Constants for the programmable I/O port block and its host bus decoder.
// Assumes a single 100 MHz clock and a plain register port of 8-bit data.
package io_port_pkg;
    localparam int NPORT = 7;
    localparam int PW = 8;
    localparam int AW = 6;
    // First port index that owns a per-pin control register.
    localparam int CTL_FIRST = 4;
    // Ports below this index hold input macrocells.
    localparam int IMC_PORTS = 3;
    // Ports that carry the low and high data bytes of a 16-bit bus.
    localparam int DATA_LO_PORT = 5;
    localparam int DATA_HI_PORT = 6;
    // Register index within one port block, port number in bits 5:3.
    localparam logic [2:0] REG_DOUT = 3'h0;
    localparam logic [2:0] REG_DIR = 3'h1;
    localparam logic [2:0] REG_CTL = 3'h2;
    localparam logic [2:0] REG_PIN = 3'h3;
    localparam logic [2:0] REG_MCELL = 3'h4;
    localparam logic [AW-1:0] REG_BUSCFG = 6'h38;
    localparam logic [PW-1:0] RST_DOUT = 8'h00;
    localparam logic [PW-1:0] RST_DIR = 8'h00;
    localparam logic [PW-1:0] RST_CTL = 8'h00;
    localparam logic [2:0] RST_BUSCFG = 3'h0;
    localparam int SYNC_STAGES = 2;
    // Output source chosen by programmed setup.
    localparam logic [1:0] SRC_DOUT = 2'h0;
    localparam logic [1:0] SRC_ADDR = 2'h1;
    localparam logic [1:0] SRC_MCELL = 2'h2;
    localparam logic [1:0] SRC_CS = 2'h3;
    // Input macrocell kind.
    localparam logic [1:0] IMC_DIRECT = 2'h0;
    localparam logic [1:0] IMC_LATCH = 2'h1;
    localparam logic [1:0] IMC_REG = 2'h2;
    typedef enum logic [1:0] {
        MODE_WR_RD_BHE,
        MODE_RD_WRL_WRH,
        MODE_SIZE
    } bus_mode_t;
endpackage : io_port_pkg

// [hdl/io_port_block.sv]
// Seven programmable I/O ports with host bus byte-lane and address decode.
// Assumes pin and host bus inputs are asynchronous and the logic array
// signals come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module io_port_block #(
    parameter int NP = io_port_pkg::NPORT,
    parameter int W = io_port_pkg::PW
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [io_port_pkg::AW-1:0] addr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [W-1:0] rdata_o,
    input wire logic [NP*W-1:0] pin_i,
    output logic [NP*W-1:0] pin_o,
    output logic [NP*W-1:0] pin_oe_o,
    input wire logic [NP*2-1:0] setup_src_i,
    input wire logic [NP*W-1:0] logic_out_i,
    input wire logic [NP*W-1:0] logic_oe_i,
    input wire logic [NP*W-1:0] logic_cs_i,
    input wire logic [io_port_pkg::IMC_PORTS*2-1:0] imc_kind_i,
    input wire logic [io_port_pkg::IMC_PORTS-1:0] imc_clk_sel_i,
    input wire logic imc_clk_term_i,
    output logic [io_port_pkg::IMC_PORTS*W-1:0] imc_o,
    input wire logic data_port_en_i,
    input wire logic [15:0] host_dout_i,
    output logic [15:0] host_din_o,
    input wire logic [2:0] bus_control_inputs_n_i,
    input wire logic high_write_pin_n_i,
    input wire logic strobe_pin_i,
    input wire logic a0_i,
    input wire logic [2:0] addr_lo_i,
    input wire logic [15:0] ad_i,
    output logic [18:0] bus_addr_o,
    output logic bus_rd_o,
    output logic bus_wr_o,
    output logic lane_lo_o,
    output logic lane_hi_o
);
    import io_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: pins and host bus are asynchronous.
    localparam int BW = NP*W + 3 + 1 + 1 + 1 + 3 + 16;
    logic [BW-1:0] sync1_q, sync2_q;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce_i) begin
            sync1_q <= {pin_i, bus_control_inputs_n_i, high_write_pin_n_i,
                        strobe_pin_i, a0_i, addr_lo_i, ad_i};
            sync2_q <= sync1_q;
        end
    end
    wire [NP*W-1:0] pin_s = sync2_q[BW-1 -: NP*W];
    wire [2:0] ctl_n_s = sync2_q[24:22];
    wire hwr_n_s = sync2_q[21];
    wire stb_s = sync2_q[20];
    wire a0_s = sync2_q[19];
    wire [2:0] alo_s = sync2_q[18:16];
    wire [15:0] ad_s = sync2_q[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Host register port.
    logic [NP*W-1:0] dout_q, dir_q, ctl_q;
    logic [2:0] buscfg_q;
    wire [2:0] rport = addr_i[5:3];
    wire [2:0] rreg = addr_i[2:0];
    wire port_ok = (int'(rport) < NP);
    wire ctl_ok = (int'(rport) >= CTL_FIRST);
    wire hit_cfg = (addr_i == REG_BUSCFG);

    function automatic logic [W-1:0] pick(input logic [NP*W-1:0] v,
                                          input logic [2:0] p);
        pick = v[p*W +: W];
    endfunction : pick

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dout_q <= {NP{RST_DOUT}};
            dir_q <= {NP{RST_DIR}};
            ctl_q <= {NP{RST_CTL}};
            buscfg_q <= RST_BUSCFG;
        end else if (ce_i && wr_i) begin
            if (port_ok && rreg == REG_DOUT)
                dout_q[rport*W +: W] <= wdata_i;
            if (port_ok && rreg == REG_DIR)
                dir_q[rport*W +: W] <= wdata_i;
            if (port_ok && ctl_ok && rreg == REG_CTL)
                ctl_q[rport*W +: W] <= wdata_i;
            if (hit_cfg)
                buscfg_q <= wdata_i[2:0];
        end
    end

    wire [W-1:0] mcell_rd = (int'(rport) < IMC_PORTS) ?
        imc_o[rport*W +: W] : pick(logic_out_i, rport);
    wire [W-1:0] rd_mux =
        hit_cfg ? {{(W-3){1'b0}}, buscfg_q} :
        !port_ok ? '0 :
        (rreg == REG_DOUT) ? pick(dout_q, rport) :
        (rreg == REG_DIR) ? pick(dir_q, rport) :
        (rreg == REG_CTL) ? pick(ctl_q, rport) :
        (rreg == REG_PIN) ? pick(pin_s, rport) :
        (rreg == REG_MCELL) ? mcell_rd : '0;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            rdata_o <= '0;
        else if (ce_i)
            rdata_o <= rd_i ? rd_mux : '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Host bus decode.
    wire [1:0] mode = buscfg_q[1:0];
    wire latch_en = buscfg_q[2];
    logic stb_q;
    logic [15:0] upper_q;
    wire stb_fall = stb_q && !stb_s;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stb_q <= 1'b0;
            upper_q <= '0;
        end else if (ce_i) begin
            stb_q <= stb_s;
            if (!latch_en || stb_fall)
                upper_q <= ad_s;
        end
    end

    logic rd_d, wr_d, lo_d, hi_d;
    always_comb begin
        rd_d = 1'b0;
        wr_d = 1'b0;
        lo_d = 1'b0;
        hi_d = 1'b0;
        case (mode)
            MODE_WR_RD_BHE: begin
                wr_d = !ctl_n_s[0];
                rd_d = !ctl_n_s[1];
                lo_d = !a0_s;
                hi_d = !ctl_n_s[2];
            end
            MODE_RD_WRL_WRH: begin
                rd_d = !ctl_n_s[1];
                wr_d = !ctl_n_s[0] || !hwr_n_s;
                lo_d = rd_d || !ctl_n_s[0];
                hi_d = rd_d || !hwr_n_s;
            end
            MODE_SIZE: begin
                rd_d = !ctl_n_s[1] && ctl_n_s[0];
                wr_d = !ctl_n_s[1] && !ctl_n_s[0];
                hi_d = !ctl_n_s[2] || !a0_s;
                lo_d = !ctl_n_s[2] || a0_s;
            end
            default: begin
                rd_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_addr_o <= '0;
            bus_rd_o <= 1'b0;
            bus_wr_o <= 1'b0;
            lane_lo_o <= 1'b0;
            lane_hi_o <= 1'b0;
        end else if (ce_i) begin
            bus_addr_o <= {upper_q, alo_s};
            bus_rd_o <= rd_d;
            bus_wr_o <= wr_d;
            lane_lo_o <= lo_d;
            lane_hi_o <= hi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output multiplexer and driver enable per pin.
    logic [NP*W-1:0] pin_d, oe_d;
    wire dport_rd = data_port_en_i && rd_d;
    always_comb begin
        pin_d = '0;
        oe_d = '0;
        for (int p = 0; p < NP; p++) begin
            for (int b = 0; b < W; b++) begin
                logic [1:0] sel;
                sel = setup_src_i[p*2 +: 2];
                if (p >= CTL_FIRST)
                    sel = ctl_q[p*W+b] ? SRC_ADDR : SRC_DOUT;
                case (sel)
                    SRC_DOUT: pin_d[p*W+b] = dout_q[p*W+b];
                    SRC_ADDR: pin_d[p*W+b] = upper_q[(p*W+b) % 16];
                    SRC_MCELL: pin_d[p*W+b] = logic_out_i[p*W+b];
                    SRC_CS: pin_d[p*W+b] = logic_cs_i[p*W+b];
                    default: pin_d[p*W+b] = 1'b0;
                endcase
                oe_d[p*W+b] = logic_oe_i[p*W+b] | dir_q[p*W+b];
            end
        end
        if (data_port_en_i) begin
            pin_d[DATA_LO_PORT*W +: 8] = host_dout_i[7:0];
            pin_d[DATA_HI_PORT*W +: 8] = host_dout_i[15:8];
            oe_d[DATA_LO_PORT*W +: 8] = {8{dport_rd && lo_d}};
            oe_d[DATA_HI_PORT*W +: 8] = {8{dport_rd && hi_d}};
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_o <= '0;
            pin_oe_o <= '0;
            host_din_o <= '0;
        end else if (ce_i) begin
            pin_o <= pin_d;
            pin_oe_o <= oe_d;
            host_din_o <= {pick(pin_s, 3'(DATA_HI_PORT)),
                           pick(pin_s, 3'(DATA_LO_PORT))};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input macrocells. The latch is modelled as a clocked follower, so it
    // trails the pin by one cycle while open; a true latch would glitch.
    logic [IMC_PORTS*W-1:0] cell_q;
    logic [IMC_PORTS-1:0] cclk_q;
    logic [IMC_PORTS-1:0] cclk;
    logic [IMC_PORTS*W-1:0] imc_d;
    always_comb begin
        imc_d = '0;
        for (int p = 0; p < IMC_PORTS; p++) begin
            cclk[p] = imc_clk_sel_i[p] ? imc_clk_term_i : stb_s;
            case (imc_kind_i[p*2 +: 2])
                IMC_DIRECT: imc_d[p*W +: W] = pin_s[p*W +: W];
                IMC_LATCH: imc_d[p*W +: W] = cclk[p] ?
                    pin_s[p*W +: W] : cell_q[p*W +: W];
                IMC_REG: imc_d[p*W +: W] = (cclk[p] && !cclk_q[p]) ?
                    pin_s[p*W +: W] : cell_q[p*W +: W];
                default: imc_d[p*W +: W] = pin_s[p*W +: W];
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cell_q <= '0;
            cclk_q <= '0;
            imc_o <= '0;
        end else if (ce_i) begin
            cell_q <= imc_d;
            cclk_q <= cclk;
            imc_o <= imc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_dir_write;
        ce_i && wr_i && port_ok && rreg == REG_DIR;
    endsequence
    sequence s_read_back(logic [W-1:0] v);
        ce_i && rd_i ##1 rdata_o == v;
    endsequence

    a_dir_readback: assert property (
        s_dir_write ##1 (ce_i && rd_i && $stable(addr_i))
        |=> rdata_o == $past(wdata_i, 2))
        else $error("direction readback differs from last write");
    a_unmapped_zero: assert property (
        (ce_i && rd_i && !port_ok && !hit_cfg) |=> rdata_o == '0)
        else $error("unmapped read gave nonzero data");
    a_idle_rdata: assert property (
        (ce_i && !rd_i) |=> rdata_o == '0)
        else $error("read data stands outside its cycle");
    a_oe_or: assert property (
        (ce_i && !data_port_en_i) |=> pin_oe_o == $past(logic_oe_i | dir_q))
        else $error("driver enable is not the OR of its inputs");
    a_dir_alone: assert property (
        (ce_i && !data_port_en_i && logic_oe_i == '0)
        |=> pin_oe_o == $past(dir_q))
        else $error("direction bit did not control the driver");
    a_hostio_dout: assert property (
        (ce_i && !data_port_en_i && ctl_q[CTL_FIRST*W] == 1'b0)
        |=> pin_o[CTL_FIRST*W] == $past(dout_q[CTL_FIRST*W]))
        else $error("host I/O pin not driven from data-out");
    a_upper_hold: assert property (
        (ce_i && latch_en && !stb_fall) ##1 ce_i |=> $stable(upper_q)
        or $past(stb_fall))
        else $error("upper address changed without a strobe");
    a_size_lane: assert property (
        (ce_i && mode == MODE_SIZE && !ctl_n_s[2] == 1'b0 && a0_s)
        |=> lane_lo_o && !lane_hi_o)
        else $error("odd byte not on the low lane");
    a_reset_undriven: assert property (
        $rose(nrst_i) |-> pin_oe_o == '0 && dir_q == '0 && ctl_q == '0)
        else $error("pins driven straight after reset");
endmodule : io_port_block
`default_nettype wire

// [testbench/host_mcu_model.sv]
// Behavioural host microcontroller on the external bus of the port block.
// Assumes the bench calls its tasks and shares the block's clock.
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
    input wire logic ref_clk_i,
    output logic [15:0] ad_o,
    output logic strobe_o,
    output logic [2:0] addr_lo_o,
    output logic a0_o,
    output logic [2:0] ctl_n_o,
    output logic high_write_n_o
);
    initial begin
        ad_o = 16'h0000;
        strobe_o = 1'b0;
        addr_lo_o = 3'h0;
        a0_o = 1'b0;
        ctl_n_o = 3'h7;
        high_write_n_o = 1'b1;
    end
    // strobe only when latching.
    // The shared lines turn to data after the hold, so a block that fails
    // to latch sees a different upper address.
    task automatic latch(input logic [15:0] upper);
        @(posedge ref_clk_i);
        ad_o <= upper;
        strobe_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        strobe_o <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        ad_o <= ~upper;
    endtask : latch
    task automatic step(input logic [2:0] lo);
        @(posedge ref_clk_i);
        addr_lo_o <= lo;
        ad_o <= ~ad_o;
    endtask : step
    task automatic ctl(input logic [2:0] c, input logic hw, input logic a0);
        @(posedge ref_clk_i);
        ctl_n_o <= c;
        high_write_n_o <= hw;
        a0_o <= a0;
    endtask : ctl
endmodule : host_mcu_model
`default_nettype wire

// [testbench/mcu_bus_io_port_arch_test.sv]
// Self-checking bench for the I/O port block and its host bus decode.
// Assumes the host model drives the external bus pins.
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_io_port_arch_test;
    import io_port_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [55:0] pin_in = '0;
    logic [55:0] lout = '0;
    logic [55:0] loe = '0;
    logic [55:0] lcs = '0;
    logic [55:0] pin_out, pin_oe;
    logic [13:0] src = '0;
    logic [5:0] ikind = '0;
    logic [2:0] isel = '0;
    logic iterm = 1'b0;
    logic dpen = 1'b0;
    logic [23:0] input_macrocell;
    logic [15:0] hdin;
    logic [15:0] ad;
    logic strobe, a0, hw_n, brd, bwr, lane_lo, lane_hi;
    logic [2:0] lo, cntl_n;
    logic [18:0] baddr;
    logic [1:0] exp_src [3] = '{SRC_DOUT, SRC_MCELL, SRC_CS};
    logic [7:0] exp_val [3] = '{8'h96, 8'hc3, 8'h3c};
    logic [1:0] lanes [4] = '{2'h3, 2'h3, 2'h2, 2'h1};
    int n_mismatch = 0;
    int check_count = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    host_mcu_model host (.ref_clk_i(ref_clk_i), .ad_o(ad), .strobe_o(strobe),
        .addr_lo_o(lo), .a0_o(a0), .ctl_n_o(cntl_n), .high_write_n_o(hw_n));
    io_port_block uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe),
        .setup_src_i(src), .logic_out_i(lout), .logic_oe_i(loe),
        .logic_cs_i(lcs), .imc_kind_i(ikind), .imc_clk_sel_i(isel),
        .imc_clk_term_i(iterm), .imc_o(input_macrocell), .data_port_en_i(dpen),
        .host_dout_i(16'h0000), .host_din_o(hdin),
        .bus_control_inputs_n_i(cntl_n), .high_write_pin_n_i(hw_n),
        .strobe_pin_i(strobe), .a0_i(a0), .addr_lo_i(lo), .ad_i(ad),
        .bus_addr_o(baddr), .bus_rd_o(brd), .bus_wr_o(bwr),
        .lane_lo_o(lane_lo), .lane_hi_o(lane_hi));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] ra(input int p, input logic [2:0] r);
        return {p[2:0], r};
    endfunction : ra
    task automatic chk(input logic [55:0] got, input logic [55:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask : wreg
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        chk({48'h0, rdata}, {48'h0, e});
    endtask : rchk
    // Waits past the two-flop sync and the output register.
    task automatic settle();
        repeat (5) @(posedge ref_clk_i);
        #1;
    endtask : settle
    task automatic summarize();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        chk(pin_oe, 56'h0);
        for (int p = 0; p < NPORT; p++) begin
            rchk(ra(p, REG_DIR), RST_DIR);
            rchk(ra(p, REG_CTL), RST_CTL);
            rchk(ra(p, REG_DOUT), RST_DOUT);
        end
        wreg(ra(1, REG_DIR), 8'hff);
        rchk(ra(1, REG_DIR), 8'hff);
        @(posedge ref_clk_i);
        addr <= ra(1, REG_DIR);
        wdata <= 8'h5c;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        chk({48'h0, rdata}, {48'h0, 8'h5c});
        wreg(ra(1, REG_DIR), 8'hff);
        wreg(ra(4, REG_DOUT), 8'ha5);
        wreg(ra(4, REG_DIR), 8'h0f);
        wreg(ra(4, REG_CTL), 8'hf0);
        rchk(ra(4, REG_CTL), 8'hf0);
        rchk(ra(4, REG_DOUT), 8'ha5);
        wreg(ra(0, REG_CTL), 8'hff);
        rchk(ra(0, REG_CTL), 8'h00);
        rchk(6'h3f, 8'h00);
        @(posedge ref_clk_i);
        loe[16] <= 1'b1;
        pin_in[31:24] <= 8'h3c;
        settle();
        chk(pin_oe, 56'h00_000f_0001_ff00);
        chk({52'h0, pin_out[35:32]}, 56'h5);
        rchk(ra(3, REG_PIN), 8'h3c);
        wreg(ra(2, REG_DOUT), 8'h96);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_i);
            lout[23:16] <= 8'hc3;
            lcs[23:16] <= 8'h3c;
            src[5:4] <= exp_src[i];
            settle();
            chk({48'h0, pin_out[23:16]}, {48'h0, exp_val[i]});
        end
        @(posedge ref_clk_i);
        ikind <= {2'h0, IMC_DIRECT, IMC_REG};
        isel[0] <= 1'b1;
        pin_in[15:0] <= 16'h775a;
        settle();
        @(posedge ref_clk_i);
        iterm <= 1'b1;
        @(posedge ref_clk_i);
        iterm <= 1'b0;
        pin_in[7:0] <= 8'ha5;
        settle();
        chk({32'h0, input_macrocell}, {40'h0, 8'h77, 8'h5a});
        rchk(ra(0, REG_MCELL), 8'h5a);
        @(posedge ref_clk_i);
        dpen <= 1'b1;
        pin_in[55:40] <= 16'h3412;
        settle();
        chk({40'h0, hdin}, {40'h0, 16'h3412});
        wreg(REG_BUSCFG, 8'h05);
        host.ctl(3'h5, 1'b1, 1'b0);
        host.latch(16'hbeef);
        for (int s = 7; s >= 0; s--) begin
            host.step(s[2:0]);
            settle();
            chk({37'h0, baddr}, {37'h0, 16'hbeef, s[2:0]});
            chk({53'h0, brd, lane_hi, lane_lo}, 56'h7);
        end
        host.ctl(3'h7, 1'b0, 1'b0);
        settle();
        chk({52'h0, brd, bwr, lane_hi, lane_lo}, 56'h6);
        wreg(REG_BUSCFG, 8'h04);
        for (int b = 0; b < 2; b++) begin
            host.ctl(3'h3, 1'b1, b[0]);
            settle();
            chk({55'h0, lane_lo}, {55'h0, ~b[0]});
        end
        wreg(REG_BUSCFG, 8'h06);
        for (int k = 0; k < 4; k++) begin
            host.ctl({k[1], 2'h1}, 1'b1, k[0]);
            settle();
            chk({54'h0, lane_hi, lane_lo}, {54'h0, lanes[k]});
        end
        summarize();
    end
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule : mcu_bus_io_port_arch_test
`default_nettype wire
